// file: hw/imc_pkg.sv
// shared constants and types for the sensor output and calibration block
package imc_pkg;
	localparam int FRAME_BITS = 16;
	localparam int NUM_OUT = 11;
	localparam int NUM_TRIM = 6;
	localparam logic [6:0] ADR_SUPPLY = 7'h02;
	localparam logic [6:0] ADR_AUX = 7'h16;
	localparam logic [6:0] ADR_TRIM0 = 7'h1A;
	localparam logic [6:0] ADR_MISC = 7'h34;
	localparam logic [6:0] ADR_DIAG = 7'h3C;
	localparam logic [6:0] ADR_CMD = 7'h3E;
	localparam logic [5:0] IDX_SUPPLY = ADR_SUPPLY[6:1];
	localparam logic [5:0] IDX_AUX = ADR_AUX[6:1];
	localparam logic [5:0] IDX_TRIM0 = ADR_TRIM0[6:1];
	localparam logic [5:0] IDX_MISC = ADR_MISC[6:1];
	localparam logic [5:0] IDX_DIAG = ADR_DIAG[6:1];
	localparam logic [15:0] BURST_CMD = 16'h3E00;
	localparam int FLAG_NEW = 15;
	localparam int FLAG_ERR = 14;
	localparam int CMD_AUTONULL = 0;
	localparam int CMD_RESTORE = 1;
	localparam int CMD_DAC = 2;
	localparam int CMD_FLASH = 3;
	localparam int CMD_PREC = 4;
	localparam int CMD_SWRST = 7;
	localparam logic [7:0] CMD_MASK = 8'h9F;
	localparam logic [15:0] MISC_RST = 16'h0006;
	localparam int MISC_LINCOMP = 7;
	localparam int GTRIM_MSB = 12;
	localparam int ATRIM_MSB = 11;
	localparam logic [2:0] RANGE_600 = 3'b010;
	localparam logic [2:0] RANGE_300 = 3'b001;
	localparam int CORE_HZ = 25_000_000;
	localparam int FLASH_MS = 50;
	localparam int FLASH_CYC = FLASH_MS * (CORE_HZ / 1000);
	localparam int PREC_S = 30;
	localparam int PREC_CYC = PREC_S * CORE_HZ;
	localparam int RESTART_CYC = 4096;
	localparam int AVG_SHIFT = 3;

	typedef enum logic [1:0] {ST_IDLE, ST_PREC, ST_WAIT} imc_st_e;

	typedef struct packed {
		logic [15:0] sh;
		logic [3:0] cnt;
		logic [15:0] rxw;
		logic tog;
	} imc_link_s;

	typedef struct packed {
		logic [2:0] tsy;
		logic [NUM_TRIM-1:0][15:0] trim;
		logic [NUM_TRIM-1:0][15:0] trim_fl;
		logic [15:0] misc;
		logic [15:0] misc_fl;
		logic [NUM_OUT-1:0][13:0] smp;
		logic [NUM_OUT-1:0] fresh;
		logic [15:0] tx;
		logic [5:0] bidx;
		logic burst;
		logic [7:0] cmd;
		logic [31:0] tmr;
		logic [2:0][13:0] avg;
		logic dac;
		imc_st_e st;
	} imc_core_s;
endpackage

// file: hw/imc_calib_top.sv
// serial link, output words, bias trims and command engine of the inertial sensor
`timescale 1ns/1ps
`default_nettype none

module imc_link
	import imc_pkg::*;
(
	input wire logic sclk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic din,
	input wire logic [15:0] tx_word,
	output logic dout,
	output logic [15:0] rx_word,
	output logic rx_tog
);
	imc_link_s s;
	imc_link_s n;

	always_comb begin
		n = s;
		if (!cs_n) begin
			n.sh = {s.sh[14:0], din};
			n.cnt = s.cnt + 4'h1;
			if (s.cnt == 4'(FRAME_BITS - 1)) begin
				n.rxw = {s.sh[14:0], din};
				n.tog = ~s.tog;
			end
		end
	end

	always_ff @(posedge sclk or posedge rst) begin
		if (rst)
			s <= '0;
		else
			s <= n;
	end

	// word is held by the core between frames; msb shows before the first edge
	assign dout = tx_word[~s.cnt];
	assign rx_word = s.rxw;
	assign rx_tog = s.tog;
endmodule // imc_link

module imc_calib_top
	import imc_pkg::*;
#(
	parameter int FLASH_CYC_P = FLASH_CYC,
	parameter int PREC_CYC_P = PREC_CYC,
	parameter int RESTART_CYC_P = RESTART_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	input wire logic sample_valid,
	input wire logic [11:0] supply_raw,
	input wire logic [2:0][13:0] rate_raw,
	input wire logic [2:0][13:0] accel_raw,
	input wire logic [2:0][11:0] temp_raw,
	input wire logic [11:0] aux_raw,
	input wire logic [15:0] diagnostic_status,
	input wire logic [2:0] range_code,
	output logic lin_comp_en,
	output logic dac_latch,
	output logic busy
);
	imc_core_s s;
	imc_core_s n;
	logic [15:0] w;
	logic rx_tog;
	logic fr;
	logic alarm_any;
	logic [5:0] ix;
	logic signed [14:0] d;

	imc_link u_link (
		.sclk(sclk),
		.rst(rst),
		.cs_n(cs_n),
		.din(din),
		.tx_word(s.tx),
		.dout(dout),
		.rx_word(w),
		.rx_tog(rx_tog)
	);

	assign fr = s.tsy[2] ^ s.tsy[1];
	assign alarm_any = |diagnostic_status;
	assign ix = w[14:9];

	function automatic logic [13:0] gtrim(input logic [15:0] t);
		logic signed [13:0] v;
		v = 14'($signed(t[GTRIM_MSB:0]));
		case (range_code)
			RANGE_600: return v >>> 1;
			RANGE_300: return v;
			default: return v >>> 2;
		endcase
	endfunction

	function automatic logic [15:0] gneg(input logic [13:0] g);
		logic signed [15:0] p;
		p = 16'($signed(g));
		case (range_code)
			RANGE_600: p = p <<< 1;
			RANGE_300: p = p;
			default: p = p <<< 2;
		endcase
		p = -p;
		return {3'b000, p[GTRIM_MSB:0]};
	endfunction

	function automatic logic [15:0] rdw(input logic [5:0] a);
		logic [15:0] r;
		r = '0;
		for (int k = 0; k < NUM_OUT; k++) begin
			if (a == 6'(IDX_SUPPLY + k))
				r = {s.fresh[k], alarm_any, s.smp[k]};
		end
		for (int k = 0; k < NUM_TRIM; k++) begin
			if (a == 6'(IDX_TRIM0 + k))
				r = s.trim[k];
		end
		if (a == IDX_MISC)
			r = s.misc;
		if (a == IDX_DIAG)
			r = diagnostic_status;
		return r;
	endfunction

	always_comb begin
		n = s;
		d = '0;
		n.tsy = {s.tsy[1:0], rx_tog};
		n.dac = 1'b0;
		if (fr) begin
			if (s.burst) begin
				n.tx = rdw(s.bidx);
				for (int k = 0; k < NUM_OUT; k++) begin
					if (s.bidx == 6'(IDX_SUPPLY + k))
						n.fresh[k] = 1'b0;
				end
				if (s.bidx == IDX_AUX)
					n.burst = 1'b0;
				else
					n.bidx = s.bidx + 6'h01;
			end else if (w[15]) begin
				n.tx = '0;
				for (int k = 0; k < NUM_TRIM; k++) begin
					if (ix == 6'(IDX_TRIM0 + k)) begin
						if (w[8])
							n.trim[k][15:8] = w[7:0];
						else
							n.trim[k][7:0] = w[7:0];
					end
				end
				if (ix == IDX_MISC) begin
					if (w[8])
						n.misc[15:8] = w[7:0];
					else
						n.misc[7:0] = w[7:0];
				end
				if (ix == ADR_CMD[6:1] && !w[8] && s.st == ST_IDLE && s.cmd == '0)
					n.cmd = w[7:0] & CMD_MASK;
			end else if (w[15:8] == BURST_CMD[15:8]) begin
				n.tx = rdw(IDX_SUPPLY);
				n.fresh[0] = 1'b0;
				n.bidx = IDX_SUPPLY + 6'h01;
				n.burst = 1'b1;
			end else begin
				n.tx = rdw(ix);
				for (int k = 0; k < NUM_OUT; k++) begin
					if (ix == 6'(IDX_SUPPLY + k))
						n.fresh[k] = 1'b0;
				end
			end
		end
		// a fresh sample wins over a read-clear in the same cycle
		if (sample_valid && s.st == ST_IDLE) begin
			n.smp[0] = {2'b00, supply_raw};
			for (int i = 0; i < 3; i++) begin
				n.smp[1 + i] = rate_raw[i] + gtrim(s.trim[i]);
				n.smp[4 + i] = accel_raw[i] + 14'($signed(s.trim[3 + i][ATRIM_MSB:0]));
				n.smp[7 + i] = {2'b00, temp_raw[i]};
			end
			n.smp[NUM_OUT - 1] = {2'b00, aux_raw};
			n.fresh = '1;
		end
		case (s.st)
			ST_IDLE: begin
				if (s.cmd[CMD_SWRST]) begin
					n.trim = s.trim_fl;
					n.misc = s.misc_fl;
					n.smp = '0;
					n.fresh = '0;
					n.burst = 1'b0;
					n.tmr = 32'(RESTART_CYC_P - 1);
					n.st = ST_WAIT;
				end else if (s.cmd[CMD_PREC]) begin
					for (int i = 0; i < 3; i++)
						n.avg[i] = rate_raw[i];
					n.tmr = 32'(PREC_CYC_P - 1);
					n.st = ST_PREC;
				end else if (s.cmd[CMD_RESTORE]) begin
					n.trim = '0;
					n.smp = '0;
					n.fresh = '0;
					n.tmr = 32'(FLASH_CYC_P - 1);
					n.st = ST_WAIT;
				end else if (s.cmd[CMD_AUTONULL]) begin
					for (int i = 0; i < 3; i++)
						n.trim[i] = gneg(rate_raw[i]);
					n.smp = '0;
					n.fresh = '0;
					n.tmr = 32'(FLASH_CYC_P - 1);
					n.st = ST_WAIT;
				end else if (s.cmd[CMD_FLASH]) begin
					n.tmr = 32'(FLASH_CYC_P - 1);
					n.st = ST_WAIT;
				end else if (s.cmd[CMD_DAC]) begin
					n.dac = 1'b1;
					n.cmd = '0;
				end
			end
			ST_PREC: begin
				// offline: samples only feed the running average
				if (sample_valid) begin
					for (int i = 0; i < 3; i++) begin
						d = $signed({rate_raw[i][13], rate_raw[i]}) - $signed({s.avg[i][13], s.avg[i]});
						d = d >>> AVG_SHIFT;
						n.avg[i] = s.avg[i] + 14'(d);
					end
				end
				if (s.tmr == '0) begin
					for (int i = 0; i < 3; i++)
						n.trim[i] = gneg(s.avg[i]);
					n.smp = '0;
					n.fresh = '0;
					n.tmr = 32'(FLASH_CYC_P - 1);
					n.st = ST_WAIT;
				end else begin
					n.tmr = s.tmr - 32'h0000_0001;
				end
			end
			ST_WAIT: begin
				if (s.tmr == '0) begin
					if (!s.cmd[CMD_SWRST]) begin
						n.trim_fl = s.trim;
						n.misc_fl = s.misc;
					end
					n.cmd = '0;
					n.st = ST_IDLE;
				end else begin
					n.tmr = s.tmr - 32'h0000_0001;
				end
			end
			default: n.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.misc <= MISC_RST;
			s.misc_fl <= MISC_RST;
			s.st <= ST_IDLE;
		end else begin
			s <= n;
		end
	end

	assign lin_comp_en = s.misc[MISC_LINCOMP];
	assign dac_latch = s.dac;
	assign busy = s.st != ST_IDLE;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence burst_go;
		fr && !s.burst && w[15:8] == BURST_CMD[15:8];
	endsequence

	sequence burst_last;
		fr && s.burst && s.bidx == IDX_AUX;
	endsequence

	a_burst_start: assert property (burst_go |=> s.burst && s.bidx == 6'h02 && s.tx[13:0] == $past(s.smp[0]))
		else $error("burst did not start on command read");
	a_burst_end: assert property (burst_last |=> !s.burst ##1 !s.burst)
		else $error("burst did not end after the aux word");
	a_burst_flag: assert property (fr && s.burst |=> s.tx[FLAG_ERR] == $past(alarm_any))
		else $error("error flag in burst word wrong");
	a_fresh_clear: assert property (fr && !s.burst && !w[15] && ix == 6'h02 && !sample_valid
		|=> !s.fresh[1])
		else $error("new-sample flag not cleared by read");
	a_fresh_set: assert property (sample_valid && s.st == ST_IDLE && s.cmd == '0 |=> &s.fresh)
		else $error("new-sample flag not set by sample");
	a_trim_write: assert property (fr && !s.burst && w[15] && w[14:8] == ADR_TRIM0
		|=> s.trim[0][7:0] == $past(w[7:0]))
		else $error("trim low byte not written");
	a_restore_run: assert property (s.st == ST_IDLE && s.cmd == 8'h02
		|=> s.trim == '0 && s.smp == '0 && s.st == ST_WAIT)
		else $error("restore did not clear trims");
	a_autonull_run: assert property (s.st == ST_IDLE && s.cmd == 8'h01 |=> s.smp == '0 && s.st == ST_WAIT)
		else $error("autonull did not zero data");
	a_prec_start: assert property (s.st == ST_IDLE && s.cmd == 8'h10
		|=> s.st == ST_PREC && s.tmr == 32'(PREC_CYC_P - 1))
		else $error("precision null did not start");
	a_prec_quiet: assert property (s.st == ST_PREC ##1 s.st == ST_PREC |-> (s.fresh & ~$past(s.fresh)) == '0)
		else $error("new-sample flag raised while offline");
	a_cmd_clear: assert property (s.st == ST_WAIT && s.tmr == '0 |=> s.cmd == '0 && s.st == ST_IDLE)
		else $error("command bits not cleared at completion");
	a_dac_pulse: assert property (s.st == ST_IDLE && s.cmd == 8'h04 |=> dac_latch ##1 !dac_latch)
		else $error("dac latch pulse wrong");

	sequence swrst_go;
		s.st == ST_IDLE && s.cmd[CMD_SWRST];
	endsequence

	sequence sample_take;
		sample_valid && s.st == ST_IDLE && s.cmd == '0;
	endsequence

	a_swrst_load: assert property (swrst_go |=> s.trim == $past(s.trim_fl) && s.misc == $past(s.misc_fl))
		else $error("software reset did not reload saved controls");
	a_swrst_wait: assert property (swrst_go |=> s.st == ST_WAIT && s.fresh == '0 ##1 s.st == ST_WAIT)
		else $error("software reset did not hold off new data");
	a_sample_take: assert property (sample_take |=> s.smp[0] == {2'b00, $past(supply_raw)}
		&& s.smp[7] == {2'b00, $past(temp_raw[0])} && s.smp[NUM_OUT - 1] == {2'b00, $past(aux_raw)})
		else $error("sample words not formatted");
	a_busy_hold: assert property (s.st == ST_WAIT && sample_valid |=> s.smp == $past(s.smp))
		else $error("sample taken while a command runs");
	a_wait_count: assert property (s.st == ST_WAIT && s.tmr != '0
		|=> s.st == ST_WAIT && s.tmr == $past(s.tmr) - 32'h0000_0001)
		else $error("command wait did not count down");
	a_misc_write: assert property (fr && !s.burst && w[15] && w[14:8] == ADR_MISC && s.cmd == '0
		|=> s.misc[7:0] == $past(w[7:0]))
		else $error("misc control low byte not written");
	a_trim_upper: assert property (fr && !s.burst && w[15] && w[14:8] == ADR_TRIM0 + 7'h01 && s.cmd == '0
		|=> s.trim[0][15:8] == $past(w[7:0]))
		else $error("trim upper byte not written");
	a_burst_step: assert property (fr && s.burst && s.bidx != IDX_AUX && !s.cmd[CMD_SWRST]
		|=> s.burst && s.bidx == $past(s.bidx) + 6'h01)
		else $error("burst did not advance to the next word");
endmodule // imc_calib_top

`default_nettype wire

// file: hw/imc_end.sv
// intentionally empty compile unit end marker
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: test/imc_spi_master.sv
// serial master model that frames 16-bit words on the link
`timescale 1ns/1ps
`default_nettype none

module imc_spi_master (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// one frame msb first; the clock stands still high outside frames
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#15 sclk = 1'b0;
			din = w[i];
			r[i] = dout;
			#15 sclk = 1'b1;
		end
		#15 cs_n = 1'b1;
		// released line must not keep showing the last bit
		din = ~w[0];
		#1000;
	endtask
endmodule // imc_spi_master
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the sensor output and calibration block
`timescale 1ns/1ps
`default_nettype none

module tb;
	import imc_pkg::*;
	localparam int FL = 200;
	localparam int PR = 500;
	localparam int RS = 100;
	logic core_clk = 1'b0;
	logic rst = 1'b0;
	logic sclk, cs_n, din, dout, sample_valid, lin_comp_en, dac_latch, busy;
	logic [11:0] supply_raw, aux_raw;
	logic [2:0][13:0] rate_raw, accel_raw;
	logic [2:0][11:0] temp_raw;
	logic [15:0] diagnostic_status, d;
	logic [2:0] range_code;
	int bad_count = 0;
	int num_checks = 0;
	int dac_seen = 0;

	always #20 core_clk = ~core_clk;
	always @(negedge core_clk) if (dac_latch === 1'b1) dac_seen++;

	imc_calib_top #(.FLASH_CYC_P(FL), .PREC_CYC_P(PR), .RESTART_CYC_P(RS)) i_imc_calib_top (
		.core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
		.sample_valid(sample_valid), .supply_raw(supply_raw), .rate_raw(rate_raw),
		.accel_raw(accel_raw), .temp_raw(temp_raw), .aux_raw(aux_raw),
		.diagnostic_status(diagnostic_status), .range_code(range_code),
		.lin_comp_en(lin_comp_en), .dac_latch(dac_latch), .busy(busy));
	imc_spi_master i_imc_spi_master (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// read frame then a harmless frame that carries the answer
	task automatic rck(input string n, input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
		logic [15:0] r;
		i_imc_spi_master.xfer({1'b0, a, 8'h00}, r);
		i_imc_spi_master.xfer(16'h0000, r);
		check(n, r & m, e);
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		i_imc_spi_master.xfer({1'b1, a + 7'h01, v[15:8]}, d);
		i_imc_spi_master.xfer({1'b1, a, v[7:0]}, d);
	endtask

	task automatic smp(input logic [13:0] rx, input logic [13:0] ax);
		@(negedge core_clk);
		rate_raw[0] = rx;
		accel_raw[0] = ax;
		sample_valid = 1'b1;
		@(negedge core_clk);
		sample_valid = 1'b0;
	endtask

	// command write, then busy must fall after about e cycles; p feeds samples meanwhile
	task automatic cmd(input logic [7:0] c, input int e, input logic p);
		int n;
		n = 0;
		i_imc_spi_master.xfer({8'hBE, c}, d);
		check("busy_start", {15'h0000, busy}, 16'h0001);
		while (busy === 1'b1 && n < e + 20) begin
			sample_valid = p;
			@(negedge core_clk);
			n++;
		end
		sample_valid = 1'b0;
		check("busy_end", {15'h0000, busy}, 16'h0000);
		check("cmd_len", {15'h0000, n >= e - 40 && n <= e}, 16'h0001);
	endtask

	task automatic t_reset();
		check("lin_rst", {15'h0000, lin_comp_en}, 16'h0000);
		check("busy_rst", {15'h0000, busy}, 16'h0000);
		rck("misc_rst", ADR_MISC, MISC_RST, 16'hFFFF);
		for (int i = 0; i < NUM_TRIM; i++) rck("trim_rst", ADR_TRIM0 + 7'(2 * i), 16'h0000, 16'hFFFF);
		rck("unmapped", 7'h18, 16'h0000, 16'hFFFF);
	endtask

	task automatic t_read();
		smp(14'h1770, 14'h1519);
		rck("rate_nd", 7'h04, {2'b10, 14'h1770}, 16'hFFFF);
		rck("rate_rd", 7'h04, 16'h1770, 16'hFFFF);
		@(negedge core_clk);
		diagnostic_status = 16'h0004;
		rck("accel_ea", 7'h0A, {2'b11, 14'h1519}, 16'hFFFF);
		@(negedge core_clk);
		diagnostic_status = 16'h0000;
	endtask

	task automatic t_burst();
		logic [15:0] e [NUM_OUT];
		smp(14'h0001, 14'h3FFE);
		e[0] = {4'h8, supply_raw};
		for (int i = 0; i < 3; i++) begin
			e[1 + i] = {2'b10, rate_raw[i]};
			e[4 + i] = {2'b10, accel_raw[i]};
			e[7 + i] = {4'h8, temp_raw[i]};
		end
		e[10] = {4'h8, aux_raw};
		i_imc_spi_master.xfer(BURST_CMD, d);
		for (int i = 0; i < NUM_OUT; i++) begin
			i_imc_spi_master.xfer(16'h0000, d);
			check("burst_word", d, e[i]);
		end
	endtask

	task automatic t_trim();
		wr(ADR_TRIM0, 16'h1FF6);
		wr(7'h20, 16'h0005);
		rck("trim_rw", ADR_TRIM0, 16'h1FF6, 16'hFFFF);
		smp(14'h0064, 14'h1519);
		rck("rate_trim", 7'h04, {2'b10, 14'h005A}, 16'hFFFF);
		rck("accel_trim", 7'h0A, {2'b10, 14'h151E}, 16'hFFFF);
		@(negedge core_clk);
		range_code = RANGE_600;
		smp(14'h0064, 14'h1519);
		rck("rate_range", 7'h04, {2'b10, 14'h005F}, 16'hFFFF);
		@(negedge core_clk);
		range_code = 3'h4;
		smp(14'h0064, 14'h1519);
		rck("rate_wide", 7'h04, {2'b10, 14'h0061}, 16'hFFFF);
		@(negedge core_clk);
		range_code = RANGE_300;
	endtask

	task automatic t_cmds();
		cmd(8'h02, FL, 1'b0);
		rck("restore_trim", 7'h20, 16'h0000, 16'hFFFF);
		rck("restore_data", 7'h04, 16'h0000, 16'hFFFF);
		@(negedge core_clk);
		rate_raw = {14'h0000, 14'h3FFD, 14'h0007};
		cmd(8'h01, FL, 1'b0);
		rck("null_x", ADR_TRIM0, 16'h1FF9, 16'h1FFF);
		rck("null_y", 7'h1C, 16'h0003, 16'h1FFF);
		i_imc_spi_master.xfer(16'hB486, d);
		check("lin_on", {15'h0000, lin_comp_en}, 16'h0001);
		rck("misc_on", ADR_MISC, 16'h0086, 16'hFFFF);
		i_imc_spi_master.xfer(16'hBE04, d);
		check("dac_pulse", 16'(dac_seen), 16'h0001);
		cmd(8'h08, FL, 1'b0);
		@(negedge core_clk);
		rate_raw = {14'h0000, 14'h0000, 14'h0008};
		cmd(8'h10, PR + FL, 1'b1);
		rck("prec_data", 7'h04, 16'h0000, 16'hFFFF);
		rck("prec_trim", ADR_TRIM0, 16'h1FF8, 16'hFFFF);
		i_imc_spi_master.xfer(16'hB406, d);
		check("lin_off", {15'h0000, lin_comp_en}, 16'h0000);
		cmd(8'h80, RS, 1'b0);
		check("swrst_lin", {15'h0000, lin_comp_en}, 16'h0001);
	endtask

	initial begin
		sample_valid = 1'b0;
		supply_raw = 12'h814;
		aux_raw = 12'hFFF;
		rate_raw = {14'h2890, 14'h3FFF, 14'h0000};
		accel_raw = {14'h0000, 14'h2AE7, 14'h0000};
		temp_raw = {12'hE22, 12'hFFF, 12'h24C};
		diagnostic_status = 16'h0000;
		range_code = RANGE_300;
		#1 rst = 1'b1;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		t_reset();
		t_read();
		t_burst();
		t_trim();
		t_cmds();
		report_and_stop();
	end

	initial begin
		#1_000_000;
		bad_count++;
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
